/* logic/watchdog_timer.sv */
// Watchdog timer with soft reset, stop control and AXI4-Lite register access
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - The 7-bit count (soft reset bit plus six bits) drops every 3072 clocks.
// - Timeout is set in 64 steps, one decrement interval each.
// - Hardware option keeps the watchdog active from reset, activate bit forced high.
// - Software option leaves reset with the watchdog inactive.
// - Writing one to activate enables it; only a device reset disables it.
// - Active watchdog with soft reset bit zero drives reset low about 500 ns.
// - A write clearing soft reset while active triggers reset at once.
// - At 8 MHz each decrement lasts 384 microseconds.
// - Inactive under software option, the counter runs as a bit-reversed timer.
// - Wait mode leaves the watchdog running unchanged.
// - With watchdog disabled a stop instruction enters stop mode.
// - Enabled watchdog without external stop control turns stop into wait.
// - With external stop control, stop is wait on low NMI, frozen stop on high.
// - Leaving stop on an interrupt lets the counter decrement again.
// - Register bits 7..2 hold count LSB..MSB, bit 1 soft reset, bit 0 activate.
// - With activate clear, soft reset bit is the timer MSB.
// - Reset value is FEh, activate high only under the hardware option.
module watchdog_timer #(
    parameter int DIV_CYCLES = wdog_pkg::DECREMENT_CYCLES
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire wdog_pkg::axil_req_type axil_req,
    output var wdog_pkg::axil_rsp_type axil_rsp,
    // Option straps and core signals
    input wire logic activation_option,
    input wire logic external_stop_control_option,
    input wire logic nmi_level,
    input wire logic stop_request,
    input wire logic wait_request,
    input wire logic wake_interrupt,
    // Device side outputs
    output logic reset_out_n,
    output logic wait_mode,
    output logic stop_mode
);
    import wdog_pkg::*;

    localparam int PULSE_LEN = RESET_PULSE_CYCLES;
    localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(DIV_CYCLES - 1);
    localparam logic [PULSE_W-1:0] PULSE_LOAD = PULSE_W'(RESET_PULSE_CYCLES);
    localparam logic [PULSE_W-1:0] PULSE_ONE = PULSE_W'(1);
    // Pulse check: eight low cycles unrolled, the rest reached by one delay
    localparam int PULSE_TAIL = PULSE_LEN - 8;

    // Prescaler width is fixed by the state struct
    if (DIV_CYCLES < 2 || DIV_CYCLES > (1 << PRESC_W)) begin : g_bad_div
        $error("DIV_CYCLES out of range for the prescaler");
    end
    if (RESET_PULSE_CYCLES >= (1 << PULSE_W)) begin : g_bad_pulse
        $error("Reset pulse too long for its counter");
    end
    if (PULSE_LEN < 9) begin : g_short_pulse
        $error("Reset pulse too short for the length check");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Field helpers

    function automatic logic [7:0] to_reg_byte(input logic [CNT_W-1:0] c, input logic act);
        logic [7:0] b;
        b = 8'h00;
        for (int i = 0; i <= FIELD_TOP - FIELD_LOW; i++) begin
            b[FIELD_TOP - i] = c[i];
        end
        b[SOFT_RESET_POS] = c[CNT_W-1];
        b[ACTIVATE_POS] = act;
        return b;
    endfunction : to_reg_byte

    function automatic logic [CNT_W-1:0] from_reg_byte(input logic [7:0] b);
        logic [CNT_W-1:0] c;
        c = '0;
        for (int i = 0; i <= FIELD_TOP - FIELD_LOW; i++) begin
            c[i] = b[FIELD_TOP - i];
        end
        c[CNT_W-1] = b[SOFT_RESET_POS];
        return c;
    endfunction : from_reg_byte

    ////////////////////////////////////////////////////////////////////////////
    // State

    wdog_state_type s_reg;
    wdog_state_type s_next;
    logic aw_fire;
    logic w_fire;
    logic wr_do;
    logic wr_load;
    logic tick;

    always_comb begin
        s_next = s_reg;
        aw_fire = axil_req.awvalid && s_reg.rsp.awready;
        w_fire = axil_req.wvalid && s_reg.rsp.wready;
        wr_do = 1'b0;
        wr_load = 1'b0;
        tick = (s_reg.presc == PRESC_LAST) && (s_reg.power != PWR_STOP);

        // Write channels taken in either order
        if (aw_fire) begin
            s_next.aw_held = 1'b1;
            s_next.aw_ok = (axil_req.awaddr == WDOG_COUNT_OFFSET);
        end
        if (w_fire) begin
            s_next.w_held = 1'b1;
            s_next.w_byte = axil_req.wdata[7:0];
            s_next.w_lane = axil_req.wstrb[0];
        end
        if (s_next.aw_held && s_next.w_held && !s_reg.rsp.bvalid) begin
            wr_do = 1'b1;
            wr_load = s_next.aw_ok && s_next.w_lane;
            s_next.aw_held = 1'b0;
            s_next.w_held = 1'b0;
            s_next.rsp.bvalid = 1'b1;
            s_next.rsp.bresp = s_next.aw_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_reg.rsp.bvalid && axil_req.bready) begin
            s_next.rsp.bvalid = 1'b0;
        end
        s_next.rsp.awready = !s_next.aw_held && !s_next.rsp.bvalid;
        s_next.rsp.wready = !s_next.w_held && !s_next.rsp.bvalid;

        // Read channel; a read during a decrement sees the value before it
        if (axil_req.arvalid && s_reg.rsp.arready) begin
            s_next.rsp.rvalid = 1'b1;
            if (axil_req.araddr == WDOG_COUNT_OFFSET) begin
                s_next.rsp.rdata = {24'h000000, to_reg_byte(s_reg.cnt, s_reg.active)};
                s_next.rsp.rresp = RESP_OKAY;
            end else begin
                s_next.rsp.rdata = 32'h00000000;
                s_next.rsp.rresp = RESP_SLVERR;
            end
        end else if (s_reg.rsp.rvalid && axil_req.rready) begin
            s_next.rsp.rvalid = 1'b0;
        end
        s_next.rsp.arready = !s_next.rsp.rvalid;

        // Counter, activation and reset pulse
        if (s_reg.pulse != '0) begin
            // Device is in reset: watchdog returns to its reset contents at the end
            s_next.pulse = s_reg.pulse - PULSE_ONE;
            if (s_reg.pulse == PULSE_ONE) begin
                s_next.cnt = CNT_RESET;
                s_next.active = activation_option;
                s_next.presc = '0;
                s_next.power = PWR_RUN;
            end
        end else begin
            if (wr_load) begin
                s_next.cnt = from_reg_byte(s_next.w_byte);
                s_next.active = s_reg.active || s_next.w_byte[ACTIVATE_POS];
                s_next.presc = '0;
            end else if (tick) begin
                s_next.cnt = s_reg.cnt - 7'h01;
                s_next.presc = '0;
            end else if (s_reg.power != PWR_STOP) begin
                s_next.presc = s_reg.presc + 12'h001;
            end
            if (activation_option) begin
                s_next.active = 1'b1;
            end
            // Checked on the value about to be stored, so a write acts at once
            if (s_next.active && !s_next.cnt[CNT_W-1]) begin
                s_next.pulse = PULSE_LOAD;
            end
        end

        // Low power modes
        if (s_next.pulse == '0 && s_reg.pulse == '0) begin
            if (wake_interrupt) begin
                s_next.power = PWR_RUN;
            end else if (s_reg.power == PWR_RUN && stop_request) begin
                if (!s_next.active) begin
                    s_next.power = PWR_STOP;
                end else if (!external_stop_control_option) begin
                    s_next.power = PWR_WAIT;
                end else begin
                    s_next.power = nmi_level ? PWR_STOP : PWR_WAIT;
                end
            end else if (s_reg.power == PWR_RUN && wait_request) begin
                s_next.power = PWR_WAIT;
            end
        end
        s_next.reset_out_n = (s_next.pulse == '0);
        s_next.wait_mode = (s_next.power == PWR_WAIT);
        s_next.stop_mode = (s_next.power == PWR_STOP);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
            s_reg.rsp.awready <= 1'b1;
            s_reg.rsp.wready <= 1'b1;
            s_reg.rsp.arready <= 1'b1;
            s_reg.cnt <= CNT_RESET;
            s_reg.active <= activation_option;
            s_reg.reset_out_n <= 1'b1;
            s_reg.power <= PWR_RUN;
        end else begin
            s_reg <= s_next;
        end
    end

    assign axil_rsp = s_reg.rsp;
    assign reset_out_n = s_reg.reset_out_n;
    assign wait_mode = s_reg.wait_mode;
    assign stop_mode = s_reg.stop_mode;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    logic [7:0] chk_byte;
    assign chk_byte = s_next.w_byte;

    chk_decrement_interval: assert property (@(posedge aclk) disable iff (!aresetn)
        (tick && !wr_load && s_reg.pulse == '0 && !(s_reg.active && s_reg.cnt == 7'h40))
        |=> (s_reg.cnt == $past(s_reg.cnt) - 7'h01))
        else $error("Count did not drop on the interval tick");

    chk_prescaler_gap: assert property (@(posedge aclk) disable iff (!aresetn)
        (tick && !wr_load && s_reg.pulse == '0) |=> (s_reg.presc == '0))
        else $error("Prescaler did not restart after a decrement");

    chk_hw_forced: assert property (@(posedge aclk) disable iff (!aresetn)
        (activation_option && $past(activation_option) && s_reg.pulse == '0) |-> s_reg.active)
        else $error("Hardware option did not keep the watchdog active");

    chk_active_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_reg.active && s_reg.pulse != PULSE_ONE) |=> s_reg.active)
        else $error("Activate bit dropped without a device reset");

    chk_expiry_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_reg.active && !s_reg.cnt[CNT_W-1]) |-> !reset_out_n)
        else $error("Expired watchdog without reset output");

    chk_pulse_length: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(reset_out_n) |-> (!reset_out_n) [*8] ##PULSE_TAIL (!reset_out_n) ##1 reset_out_n)
        else $error("Reset pulse length wrong");

    chk_pulse_reinit: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(reset_out_n) |-> (s_reg.cnt == CNT_RESET && s_reg.active == activation_option
                                && !wait_mode && !stop_mode))
        else $error("Watchdog not reinitialised after its reset pulse");

    chk_soft_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_load && s_reg.pulse == '0 && !chk_byte[SOFT_RESET_POS]
         && (s_reg.active || chk_byte[ACTIVATE_POS])) |=> !reset_out_n)
        else $error("Soft reset write did not reset");

    chk_write_load: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_load && s_reg.pulse == '0) |=> (s_reg.cnt == from_reg_byte($past(chk_byte))))
        else $error("Write did not load the count");

    chk_stop_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_reg.power == PWR_STOP && !wr_load && s_reg.pulse == '0)
        |=> (s_reg.cnt == $past(s_reg.cnt)))
        else $error("Count moved in stop mode");

    chk_stop_as_wait: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_reg.power == PWR_RUN && stop_request && !wake_interrupt && s_reg.active
         && !external_stop_control_option && s_reg.pulse == '0 && reset_out_n
         && s_reg.cnt[CNT_W-1] && s_next.pulse == '0) |=> wait_mode)
        else $error("Stop was not turned into wait");

    chk_wake_resume: assert property (@(posedge aclk) disable iff (!aresetn)
        (stop_mode && wake_interrupt && s_reg.pulse == '0 && reset_out_n && s_next.pulse == '0)
        |=> !stop_mode)
        else $error("Interrupt did not leave stop mode");

    chk_reset_value: assert property (@(posedge aclk)
        !aresetn |=> (to_reg_byte(s_reg.cnt, 1'b0) == 8'hFE))
        else $error("Register reset value wrong");

    // Bit order checked field by field, not through the packing function
    chk_read_layout: assert property (@(posedge aclk) disable iff (!aresetn)
        (axil_req.arvalid && axil_rsp.arready && axil_req.araddr == WDOG_COUNT_OFFSET)
        |=> (axil_rsp.rdata[FIELD_TOP] == $past(s_reg.cnt[0])
             && axil_rsp.rdata[FIELD_LOW] == $past(s_reg.cnt[CNT_W-2])
             && axil_rsp.rdata[SOFT_RESET_POS] == $past(s_reg.cnt[CNT_W-1])
             && axil_rsp.rdata[ACTIVATE_POS] == $past(s_reg.active)
             && axil_rsp.rdata[31:8] == 24'h000000))
        else $error("Read data layout wrong");

    cov_expiry: cover property (@(posedge aclk) disable iff (!aresetn) $fell(reset_out_n));
    cov_write: cover property (@(posedge aclk) disable iff (!aresetn) wr_load);
    cov_stop: cover property (@(posedge aclk) disable iff (!aresetn) $rose(stop_mode));
    cov_timer_wrap: cover property (@(posedge aclk) disable iff (!aresetn)
        (!s_reg.active && tick && s_reg.cnt == 7'h00));

endmodule : watchdog_timer

`default_nettype wire

/* logic/wdog_pkg.sv */
// Constants, field layout and carrier types for the watchdog block
package wdog_pkg;

    // Bus layout
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] WDOG_COUNT_OFFSET = 8'hD8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Register fields: countdown bits stored reversed in the top six bits
    localparam int CNT_W = 7;
    localparam int FIELD_TOP = 7;
    localparam int FIELD_LOW = 2;
    localparam int SOFT_RESET_POS = 1;
    localparam int ACTIVATE_POS = 0;
    localparam logic [CNT_W-1:0] CNT_RESET = 7'h7F;

    // Timing
    localparam int DECREMENT_CYCLES = 3072;
    localparam int PRESC_W = 12;
    localparam int RESET_PULSE_NS = 500;
    localparam int CLK_PERIOD_NS = 25;
    localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_W = 5;

    typedef enum logic [1:0] {
        PWR_RUN = 2'b00,
        PWR_WAIT = 2'b01,
        PWR_STOP = 2'b10
    } power_type;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } axil_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_type;

    typedef struct packed {
        axil_rsp_type rsp;
        logic aw_held;
        logic aw_ok;
        logic w_held;
        logic [7:0] w_byte;
        logic w_lane;
        logic [CNT_W-1:0] cnt;
        logic active;
        logic [PRESC_W-1:0] presc;
        logic [PULSE_W-1:0] pulse;
        logic reset_out_n;
        power_type power;
        logic wait_mode;
        logic stop_mode;
    } wdog_state_type;

endpackage : wdog_pkg

/* tb/fw_model.sv */
// Firmware model: AXI4-Lite master that services the watchdog register
`timescale 1ns/1ps
`default_nettype none
module fw_model (
    // Clock
    input wire logic aclk,
    // Register bus
    output var wdog_pkg::axil_req_type req,
    input wire wdog_pkg::axil_rsp_type rsp,
    // Hang flag
    output var logic stuck
);
    import wdog_pkg::*;
    ////////////////////////////////////////////////////////////////
    initial begin
        req = '0;
        stuck = 1'b0;
    end
    // Address and data offered together; bready held until bvalid seen
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid && n < 64);
        r = rsp.bresp;
        req.bready <= 1'b0;
        if (n >= 64) stuck <= 1'b1;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid && n < 64);
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
        if (n >= 64) stuck <= 1'b1;
    endtask : rd
    // The count may drop between two reads, so two reads in a row must agree
    task automatic rd_stable(output logic [31:0] d);
        logic [31:0] p;
        logic [1:0] r;
        d = 32'hFFFFFFFF;
        p = 32'h00000000;
        for (int i = 0; i < 4 && p !== d; i++) begin
            p = d;
            rd(WDOG_COUNT_OFFSET, d, r);
        end
    endtask : rd_stable
    task automatic refresh();
        logic [1:0] r;
        wr(WDOG_COUNT_OFFSET, 32'h000000FE, r);
    endtask : refresh
    task automatic arm(input logic [31:0] b);
        logic [1:0] r;
        wr(WDOG_COUNT_OFFSET, {24'h000000, b[7:2], 2'h3}, r);
    endtask : arm
    task automatic guard();
        logic [31:0] d;
        logic [1:0] r;
        rd(WDOG_COUNT_OFFSET, d, r);
        if (d[ACTIVATE_POS]) wr(WDOG_COUNT_OFFSET, 32'h000000FD, r);
    endtask : guard
endmodule : fw_model
`default_nettype wire

/* tb/watchdog_timer_tb.sv */
// Self-checking bench for the watchdog timer
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_tb;
    import wdog_pkg::*;
    // Short interval keeps a full 64-step timeout near 512 cycles
    localparam int DIV = 8;
    logic aclk;
    logic aresetn;
    logic activation_option;
    logic external_stop_control_option;
    logic nmi_level;
    logic stop_request;
    logic wait_request;
    logic wake_interrupt;
    logic reset_out_n;
    logic wait_mode;
    logic stop_mode;
    logic stuck;
    axil_req_type axil_req;
    axil_rsp_type axil_rsp;
    logic [31:0] d;
    logic [1:0] r;
    int fail_count;
    int check_count;
    int pulses = 0;
    ////////////////////////////////////////////////////////////////
    watchdog_timer #(.DIV_CYCLES(DIV)) dut (
        .aclk(aclk), .aresetn(aresetn), .axil_req(axil_req), .axil_rsp(axil_rsp),
        .activation_option(activation_option),
        .external_stop_control_option(external_stop_control_option),
        .nmi_level(nmi_level), .stop_request(stop_request), .wait_request(wait_request),
        .wake_interrupt(wake_interrupt), .reset_out_n(reset_out_n),
        .wait_mode(wait_mode), .stop_mode(stop_mode)
    );
    fw_model fw (.aclk(aclk), .req(axil_req), .rsp(axil_rsp), .stuck(stuck));
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    always @(negedge reset_out_n) pulses++;
    always @(posedge aclk) begin
        if (stuck === 1'b1) begin
            fail_count++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize
    // Count bit 0 lands in byte bit 7, count MSB in bit 1
    function automatic logic [31:0] enc(input logic [6:0] c, input logic a);
        logic [31:0] v;
        v = 32'h00000000;
        for (int i = 0; i < 6; i++) v[7 - i] = c[i];
        v[1] = c[6];
        v[0] = a;
        return v;
    endfunction : enc
    task automatic do_reset(input logic hw);
        aresetn <= 1'b0;
        activation_option <= hw;
        external_stop_control_option <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask : do_reset
    task automatic strobe(input int k);
        @(posedge aclk);
        stop_request <= (k == 0);
        wait_request <= (k == 1);
        wake_interrupt <= (k == 2);
        @(posedge aclk);
        stop_request <= 1'b0;
        wait_request <= 1'b0;
        wake_interrupt <= 1'b0;
        @(posedge aclk);
    endtask : strobe
    task automatic quiet(input int len);
        int p0;
        p0 = pulses;
        repeat (len) @(posedge aclk);
        check("reset pulses", pulses - p0, 0);
    endtask : quiet
    task automatic expect_pulse(input int lo, input int hi);
        int n;
        int k;
        n = 0;
        k = 0;
        while (reset_out_n !== 1'b0 && n < hi) begin
            @(posedge aclk);
            n++;
        end
        check("reset delay", (n >= lo && n < hi), 1);
        while (reset_out_n === 1'b0 && k < 40) begin
            @(posedge aclk);
            k++;
        end
        check("reset length", k, 20);
        if (n >= hi || k >= 40) summarize();
    endtask : expect_pulse
    ////////////////////////////////////////////////////////////////
    task automatic t_sw_timer();
        do_reset(1'b0);
        fw.rd(WDOG_COUNT_OFFSET, d, r);
        check("reset value", d, 32'h000000FE);
        fw.rd(8'h04, d, r);
        check("unmapped read resp", r, RESP_SLVERR);
        check("unmapped read data", d, 32'h00000000);
        fw.wr(8'h04, 32'h00000000, r);
        check("unmapped write resp", r, RESP_SLVERR);
        fw.wr(WDOG_COUNT_OFFSET, enc(7'h41, 1'b0), r);
        repeat (3 * DIV) @(posedge aclk);
        fw.rd_stable(d);
        check("timer count", d, enc(7'h3E, 1'b0));
        quiet(2 * DIV);
        strobe(0);
        check("stop entered", stop_mode, 1'b1);
        check("no wait", wait_mode, 1'b0);
        strobe(2);
        check("stop left", stop_mode, 1'b0);
        strobe(1);
        check("wait entered", wait_mode, 1'b1);
        strobe(2);
        $display("software option timer done");
    endtask : t_sw_timer
    task automatic t_soft_reset();
        fw.arm(enc(7'h7F, 1'b1));
        fw.refresh();
        fw.rd(WDOG_COUNT_OFFSET, d, r);
        check("activate kept", d, 32'h000000FF);
        fw.guard();
        expect_pulse(0, 6);
        fw.rd(WDOG_COUNT_OFFSET, d, r);
        check("after soft reset", d, 32'h000000FE);
        $display("soft reset done");
    endtask : t_soft_reset
    task automatic t_hw_timeout();
        do_reset(1'b1);
        fw.rd(WDOG_COUNT_OFFSET, d, r);
        check("hw reset value", d, 32'h000000FF);
        fw.refresh();
        fw.rd(WDOG_COUNT_OFFSET, d, r);
        check("activate forced", d, 32'h000000FF);
        fw.refresh();
        expect_pulse(64 * DIV - 3, 64 * DIV + 4);
        for (int i = 0; i < 3; i++) begin
            fw.refresh();
            quiet(60 * DIV);
        end
        fw.wr(WDOG_COUNT_OFFSET, enc(7'h40, 1'b1), r);
        expect_pulse(DIV - 2, DIV + 4);
        $display("hardware timeout done");
    endtask : t_hw_timeout
    task automatic t_hw_power();
        fw.refresh();
        strobe(0);
        check("stop as wait", wait_mode, 1'b1);
        check("stop refused", stop_mode, 1'b0);
        expect_pulse(60 * DIV, 64 * DIV + 4);
        check("run after reset", wait_mode, 1'b0);
        external_stop_control_option <= 1'b1;
        nmi_level <= 1'b0;
        fw.refresh();
        strobe(0);
        check("low nmi wait", wait_mode, 1'b1);
        strobe(2);
        nmi_level <= 1'b1;
        strobe(0);
        check("high nmi stop", stop_mode, 1'b1);
        quiet(70 * DIV);
        strobe(2);
        check("stop exit", stop_mode, 1'b0);
        expect_pulse(40 * DIV, 64 * DIV);
        $display("power modes done");
    endtask : t_hw_power
    initial begin
        fail_count = 0;
        check_count = 0;
        aresetn = 1'b0;
        activation_option = 1'b0;
        external_stop_control_option = 1'b0;
        nmi_level = 1'b0;
        stop_request = 1'b0;
        wait_request = 1'b0;
        wake_interrupt = 1'b0;
        t_sw_timer();
        t_soft_reset();
        t_hw_timeout();
        t_hw_power();
        summarize();
    end
endmodule : watchdog_timer_tb
`default_nettype wire
